/* File: core/hbp_pkg.sv */
package hbp_pkg;
  // apb word offsets
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] STATUS_OFS   = 12'h004;
  localparam logic [11:0] OUTBUF_OFS   = 12'h008;
  localparam logic [11:0] INBUF_OFS    = 12'h00c;
  localparam logic [11:0] PORT2_OFS    = 12'h010;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h014;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h018;

  // control register fields
  localparam int CTRL_FLAGS_EN_BIT = 0;
  localparam int CTRL_DMA_EN_BIT   = 1;
  localparam int CTRL_DRQ_BIT      = 2;

  // host status byte fields
  localparam int STS_OUT_FULL_BIT = 0;
  localparam int STS_IN_FULL_BIT  = 1;
  localparam int STS_F0_BIT       = 2;
  localparam int STS_CMD_BIT      = 3;
  localparam int STS_USER_LSB     = 4;
  localparam int STS_USER_W       = 4;

  // port 2 pin roles
  localparam int P2_OUT_FULL_PIN = 4;
  localparam int P2_IN_FULL_PIN  = 5;
  localparam int P2_DRQ_PIN      = 6;
  localparam int P2_GRANT_PIN    = 7;

  // interrupt event bits
  localparam int IRQ_HOST_WR_BIT = 0;
  localparam int IRQ_HOST_RD_BIT = 1;
  localparam int IRQ_DMA_BIT     = 2;
  localparam int IRQ_W           = 3;

  // reset values
  localparam logic [7:0]       PORT2_RESET    = 8'hff;
  localparam logic [2:0]       CTRL_RESET     = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
endpackage : hbp_pkg

/* File: core/host_evt_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface host_evt_if;
  logic       dma_en;
  logic       rd_active;
  logic       rd_a0;
  logic       rd_end;
  logic       wr_end;
  logic       wr_a0;
  logic [7:0] wr_data;
  logic       dma_end;
  logic [7:0] p2_pins;

  // bus front end produces events
  modport front (input dma_en, output rd_active, rd_a0, rd_end, wr_end, wr_a0, wr_data,
                 dma_end, p2_pins);
  // core consumes them
  modport core (output dma_en, input rd_active, rd_a0, rd_end, wr_end, wr_a0, wr_data,
                dma_end, p2_pins);
endinterface : host_evt_if
`default_nettype wire

/* File: core/host_bus_front.sv */
`timescale 1ns/1ns
`default_nettype none
module host_bus_front
  import hbp_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  // raw host pins
  input  wire logic       cs_n_i,
  input  wire logic       cmd_data_select_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] data_i,
  input  wire logic [7:0] p2_i,
  // events to core
  host_evt_if.front       ev
);
  localparam int RAW_W = 20;

  logic [RAW_W-1:0] s1_reg, s2_reg;
  logic             rd_prev_reg, rd_prev_next;
  logic             wr_prev_reg, wr_prev_next;
  logic             a0_hold_reg, a0_hold_next;
  logic             dma_grant_pin_hold_reg, dma_grant_pin_hold_next;
  logic [7:0]       data_hold_reg, data_hold_next;
  logic             cs_s, a0_s, rd_s, wr_s;
  logic [7:0]       d_s, p2_s;
  logic             dma_grant_pin, sel, a0_eff, rd_act, wr_act;

  // two-stage synchroniser, nothing reads stage one but stage two
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s1_reg <= {4'hf, 8'h00, 8'hff};
      s2_reg <= {4'hf, 8'h00, 8'hff};
    end
    else
    begin
      s1_reg <= {cs_n_i, cmd_data_select_i, rd_n_i, wr_n_i, data_i, p2_i};
      s2_reg <= s1_reg;
    end
  end

  assign {cs_s, a0_s, rd_s, wr_s, d_s, p2_s} = s2_reg;

  assign dma_grant_pin   = ev.dma_en & ~p2_s[P2_GRANT_PIN];
  assign sel    = ~cs_s | dma_grant_pin;
  assign a0_eff = a0_s & ~dma_grant_pin;
  assign rd_act = sel & ~rd_s;
  assign wr_act = sel & ~wr_s;

  // strobe tracking and hold of address and data
  always_comb
  begin
    rd_prev_next   = rd_act;
    wr_prev_next   = wr_act;
    a0_hold_next   = (rd_act | wr_act) ? a0_eff : a0_hold_reg;
    dma_grant_pin_hold_next = (rd_act | wr_act) ? dma_grant_pin : dma_grant_pin_hold_reg;
    data_hold_next = wr_act ? d_s : data_hold_reg;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_prev_reg   <= 1'b0;
      wr_prev_reg   <= 1'b0;
      a0_hold_reg   <= 1'b0;
      dma_grant_pin_hold_reg <= 1'b0;
      data_hold_reg <= 8'h00;
    end
    else
    begin
      rd_prev_reg   <= rd_prev_next;
      wr_prev_reg   <= wr_prev_next;
      a0_hold_reg   <= a0_hold_next;
      dma_grant_pin_hold_reg <= dma_grant_pin_hold_next;
      data_hold_reg <= data_hold_next;
    end
  end

  // events: a strobe completes on its trailing edge
  assign ev.rd_active = rd_act;
  assign ev.rd_a0     = a0_eff;
  assign ev.rd_end    = rd_prev_reg & ~rd_act;
  assign ev.wr_end    = wr_prev_reg & ~wr_act;
  assign ev.wr_a0     = a0_hold_reg;
  assign ev.wr_data   = data_hold_reg;
  assign ev.dma_end   = dma_grant_pin_hold_reg & ((rd_prev_reg & ~rd_act) | (wr_prev_reg & ~wr_act));
  assign ev.p2_pins   = p2_s;
endmodule : host_bus_front
`default_nettype wire

/* File: core/slave_host_buffer_port.sv */
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - separate host input and output buffers, neither direction overwrites the other
// - software loads the upper status nibble in one write
// - flags enable puts output-full on p2 pin 4, input-full on pin 5
// - dma enable makes p2 pin 6 request output, pin 7 grant input
// - device raises dma request to ask for a transfer
// - grant forces select and address low and drops the request
// - granted read returns output buffer, granted write loads input buffer
// - status bit 0 set on device load, cleared by host data read (address line low)
// - status bit 1 set by host write, cleared by device read
// - each host write copies the address line into the command flag
module slave_host_buffer_port
  import hbp_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  // host bus pins
  input  wire logic        cs_n_i,
  input  wire logic        cmd_data_select_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [7:0]  data_i,
  output var  logic [7:0]  data_o,
  output var  logic        data_oe_o,
  // port 2 pins
  input  wire logic [7:0]  p2_i,
  output var  logic [7:0]  p2_o,
  output var  logic [7:0]  p2_oe_o,
  // interrupt
  output var  logic        irq_o
);
  import hbp_pkg::*;

  host_evt_if ev ();

  host_bus_front u_front (
    .sys_clk_i         (sys_clk_i),
    .rstn_i            (rstn_i),
    .cs_n_i            (cs_n_i),
    .cmd_data_select_i (cmd_data_select_i),
    .rd_n_i            (rd_n_i),
    .wr_n_i            (wr_n_i),
    .data_i            (data_i),
    .p2_i              (p2_i),
    .ev                (ev)
  );

  logic [7:0]       out_buf_reg, out_buf_next;
  logic [7:0]       in_buf_reg, in_buf_next;
  logic             out_full_reg, out_full_next;
  logic             in_full_reg, in_full_next;
  logic             f0_reg, f0_next;
  logic             cmd_flag_reg, cmd_flag_next;
  logic [3:0]       user_reg, user_next;
  logic [2:0]       ctrl_reg, ctrl_next;
  logic [7:0]       port2_reg, port2_next;
  logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [31:0]      prdata_next;
  logic             pready_next, pslverr_next, irq_next;
  logic [7:0]       data_next, p2_next, p2_oe_next;
  logic             data_oe_next;
  logic [7:0]       status_byte;
  logic             setup, access, wr_acc, rd_acc, mapped;
  logic             flags_en, dma_en, dma_request_pin;
  logic             host_wr_buf, host_rd_buf;

  // apb phases: zero-wait, one access cycle after setup
  assign setup  = psel_i & ~penable_i;
  assign access = psel_i & penable_i & pready_o;
  assign wr_acc = access & pwrite_i;
  assign rd_acc = access & ~pwrite_i;
  assign mapped = (paddr_i == CTRL_OFS) || (paddr_i == STATUS_OFS) ||
                  (paddr_i == OUTBUF_OFS) || (paddr_i == INBUF_OFS) ||
                  (paddr_i == PORT2_OFS) || (paddr_i == IRQ_STAT_OFS) ||
                  (paddr_i == IRQ_MASK_OFS);

  assign flags_en = ctrl_reg[CTRL_FLAGS_EN_BIT];
  assign dma_en   = ctrl_reg[CTRL_DMA_EN_BIT];
  assign dma_request_pin      = ctrl_reg[CTRL_DRQ_BIT];
  assign ev.dma_en = dma_en;

  // host side buffer accesses
  assign host_wr_buf = ev.wr_end;
  assign host_rd_buf = ev.rd_end & ~ev.wr_a0;

  assign status_byte = {user_reg, cmd_flag_reg, f0_reg, in_full_reg, out_full_reg};

  // buffers, flags and status
  always_comb
  begin
    out_buf_next  = out_buf_reg;
    in_buf_next   = in_buf_reg;
    out_full_next = out_full_reg;
    in_full_next  = in_full_reg;
    f0_next       = f0_reg;
    cmd_flag_next = cmd_flag_reg;
    user_next     = user_reg;
    if (host_rd_buf)
      out_full_next = 1'b0;
    if (rd_acc && paddr_i == INBUF_OFS)
      in_full_next = 1'b0;
    if (host_wr_buf)
    begin
      in_buf_next  = ev.wr_data;
      // host write sets input-full, wins over clear
      in_full_next = 1'b1;
    end
    if (wr_acc && paddr_i == STATUS_OFS)
    begin
      user_next     = pwdata_i[STS_USER_LSB +: STS_USER_W];
      f0_next       = pwdata_i[STS_F0_BIT];
      cmd_flag_next = pwdata_i[STS_CMD_BIT];
    end
    // address line copied on host write
    if (host_wr_buf)
      cmd_flag_next = ev.wr_a0;
    if (wr_acc && paddr_i == OUTBUF_OFS)
    begin
      out_buf_next  = pwdata_i[7:0];
      // device load sets output-full, wins over clear
      out_full_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      out_buf_reg  <= 8'h00;
      in_buf_reg   <= 8'h00;
      out_full_reg <= 1'b0;
      in_full_reg  <= 1'b0;
      f0_reg       <= 1'b0;
      cmd_flag_reg <= 1'b0;
      user_reg     <= 4'h0;
    end
    else
    begin
      out_buf_reg  <= out_buf_next;
      in_buf_reg   <= in_buf_next;
      out_full_reg <= out_full_next;
      in_full_reg  <= in_full_next;
      f0_reg       <= f0_next;
      cmd_flag_reg <= cmd_flag_next;
      user_reg     <= user_next;
    end
  end

  // control, port latch and interrupt registers
  always_comb
  begin
    ctrl_next     = ctrl_reg;
    port2_next    = port2_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (wr_acc && paddr_i == CTRL_OFS)
      ctrl_next = pwdata_i[2:0];
    if (dma_en && !ev.p2_pins[P2_GRANT_PIN])
      ctrl_next[CTRL_DRQ_BIT] = 1'b0;
    if (wr_acc && paddr_i == PORT2_OFS)
      port2_next = pwdata_i[7:0];
    if (wr_acc && paddr_i == IRQ_MASK_OFS)
      irq_mask_next = pwdata_i[IRQ_W-1:0];
    if (wr_acc && paddr_i == IRQ_STAT_OFS)
      irq_stat_next = irq_stat_reg & ~pwdata_i[IRQ_W-1:0];
    // events set after the clear so they win
    if (host_wr_buf)
      irq_stat_next[IRQ_HOST_WR_BIT] = 1'b1;
    if (host_rd_buf)
      irq_stat_next[IRQ_HOST_RD_BIT] = 1'b1;
    if (ev.dma_end)
      irq_stat_next[IRQ_DMA_BIT] = 1'b1;
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_reg     <= CTRL_RESET;
      port2_reg    <= PORT2_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
      irq_stat_reg <= '0;
      irq_o        <= 1'b0;
    end
    else
    begin
      ctrl_reg     <= ctrl_next;
      port2_reg    <= port2_next;
      irq_mask_reg <= irq_mask_next;
      irq_stat_reg <= irq_stat_next;
      irq_o        <= irq_next;
    end
  end

  // apb answer prepared in the setup cycle
  always_comb
  begin
    pready_next  = setup;
    pslverr_next = setup & ~mapped;
    prdata_next  = prdata_o;
    if (setup)
    begin
      prdata_next = 32'h0000_0000;
      case (paddr_i)
        CTRL_OFS:     prdata_next[2:0] = ctrl_reg;
        STATUS_OFS:   prdata_next[7:0] = status_byte;
        OUTBUF_OFS:   prdata_next[7:0] = out_buf_reg;
        INBUF_OFS:    prdata_next[7:0] = in_buf_reg;
        PORT2_OFS:    prdata_next[7:0] = ev.p2_pins;
        IRQ_STAT_OFS: prdata_next[IRQ_W-1:0] = irq_stat_reg;
        IRQ_MASK_OFS: prdata_next[IRQ_W-1:0] = irq_mask_reg;
        default:      prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      prdata_o  <= prdata_next;
      pready_o  <= pready_next;
      pslverr_o <= pslverr_next;
    end
  end

  // host data bus drive during a selected read
  always_comb
  begin
    data_oe_next = ev.rd_active;
    data_next    = ev.rd_a0 ? status_byte : out_buf_reg;
  end

  // port 2 pin roles, ordinary bits drive low only
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_p2
      always_comb
      begin
        p2_next[gi]    = 1'b0;
        p2_oe_next[gi] = ~port2_reg[gi];
        if (gi == P2_OUT_FULL_PIN && flags_en)
        begin
          p2_next[gi]    = out_full_reg;
          p2_oe_next[gi] = 1'b1;
        end
        else if (gi == P2_IN_FULL_PIN && flags_en)
        begin
          p2_next[gi]    = in_full_reg;
          p2_oe_next[gi] = 1'b1;
        end
        else if (gi == P2_DRQ_PIN && dma_en)
        begin
          p2_next[gi]    = dma_request_pin;
          p2_oe_next[gi] = 1'b1;
        end
        else if (gi == P2_GRANT_PIN && dma_en)
        begin
          p2_next[gi]    = 1'b0;
          p2_oe_next[gi] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
      p2_o      <= 8'h00;
      p2_oe_o   <= 8'h00;
    end
    else
    begin
      data_o    <= data_next;
      data_oe_o <= data_oe_next;
      p2_o      <= p2_next;
      p2_oe_o   <= p2_oe_next;
    end
  end
endmodule : slave_host_buffer_port
`default_nettype wire

/* File: verif/slave_host_buffer_port_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module slave_host_buffer_port_asserts
  import hbp_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic        pready_o,
  // host pins
  input wire logic        cs_n_i,
  input wire logic        cmd_data_select_i,
  input wire logic        rd_n_i,
  input wire logic        wr_n_i,
  input wire logic        data_oe_o,
  // port 2
  input wire logic [7:0]  p2_i,
  input wire logic [7:0]  p2_o,
  input wire logic [7:0]  p2_oe_o
);
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // selected read, granted transfer, apb access edge
  wire logic sel_rd = !rd_n_i && (!cs_n_i || (!p2_i[7] && p2_oe_o[6]));
  wire logic gnt_x  = !p2_i[7] && !(rd_n_i && wr_n_i) && p2_oe_o[6];
  wire logic acc    = psel_i && penable_i && pready_o;
  // apb answer timing
  property p_ready; psel_i && !penable_i |=> pready_o && penable_i; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_pulse; pready_o |=> !pready_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  // host bus drive
  property p_rd_oe; sel_rd [*5] |-> data_oe_o; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("bus not driven on read");
  property p_no_oe; rd_n_i [*5] |-> !data_oe_o; endproperty
  a_no_oe: assert property (p_no_oe) else $error("bus driven without read");
  // flag pins follow buffer traffic, request pin drops after grant
  property p_of_set; acc && pwrite_i && paddr_i == OUTBUF_OFS && p2_oe_o[4] |=> ##[0:2] p2_o[4];
  endproperty
  a_of_set: assert property (p_of_set) else $error("out full not set");
  property p_of_clr;
    $rose(rd_n_i) && !$past(cs_n_i) && !$past(cmd_data_select_i) && p2_oe_o[4]
      |-> ##[1:4] !p2_o[4];
  endproperty
  a_of_clr: assert property (p_of_clr) else $error("out full not cleared");
  property p_if_set; $rose(wr_n_i) && !$past(cs_n_i) && p2_oe_o[5] |-> ##[1:4] p2_o[5];
  endproperty
  a_if_set: assert property (p_if_set) else $error("in full not set");
  property p_if_clr; acc && !pwrite_i && paddr_i == INBUF_OFS && p2_oe_o[5] |=> ##[0:2] !p2_o[5];
  endproperty
  a_if_clr: assert property (p_if_clr) else $error("in full not cleared");
  property p_req_drop; gnt_x ##1 !gnt_x |-> ##[0:4] !p2_o[6]; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after grant");
  // main scenarios
  c_dma_rd: cover property (!p2_i[7] && !rd_n_i);
  c_dma_wr: cover property (!p2_i[7] && !wr_n_i);
  c_cmd_wr: cover property (!cs_n_i && !wr_n_i && cmd_data_select_i);
endmodule : slave_host_buffer_port_asserts
`default_nettype wire

/* File: verif/host_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_master_model (
  // clock and device bus output
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] data_o,
  // host pins
  output var  logic       cs_n_o,
  output var  logic       cmd_data_select_o,
  output var  logic       rd_n_o,
  output var  logic       wr_n_o,
  output var  logic [7:0] hd_o,
  output var  logic       grant_n_o
);
  // idle pins
  initial
  begin
    cs_n_o = 1'b1;
    cmd_data_select_o = 1'b0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    hd_o = 8'h00;
    grant_n_o = 1'b1;
  end
  // one host or granted byte, strobe low six cycles
  task automatic xfer(input logic wr, input logic sel, input logic dma,
                      input logic [7:0] wd, output logic [7:0] rd);
    @(posedge sys_clk_i);
    grant_n_o <= !dma;
    cs_n_o <= dma;
    cmd_data_select_o <= sel | dma;
    rd_n_o <= wr;
    wr_n_o <= !wr;
    hd_o <= wr ? wd : ~hd_o;
    repeat (6) @(posedge sys_clk_i);
    rd = data_o;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    cs_n_o <= 1'b1;
    grant_n_o <= 1'b1;
    hd_o <= ~hd_o;
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask : xfer
endmodule : host_master_model
`default_nettype wire

/* File: verif/slave_host_buffer_port_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module slave_host_buffer_port_tb_top;
  import hbp_pkg::*;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic er;} row_t;
  logic        clk, rstn, psel, pen, pwr, pready, pslverr, cs_n, cds, rd_n, wr_n, grant_n;
  logic        data_oe, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  hd, data_i, data_o, d, p2_i, p2_o, p2_oe;
  int          n_fail, n_compared;
  row_t        rows [9] = '{'{0, CTRL_OFS, 0, 0, 0}, '{0, IRQ_MASK_OFS, 0, 0, 0},
    '{0, PORT2_OFS, 0, 32'hff, 0}, '{1, STATUS_OFS, 32'ha4, 0, 0}, '{0, STATUS_OFS, 0, 32'ha4, 0},
    '{1, STATUS_OFS, 32'h50, 0, 0}, '{0, STATUS_OFS, 0, 32'h50, 0}, '{0, 12'h01c, 0, 0, 1},
    '{1, 12'h01c, 32'hff, 0, 1}};
  // shared bus line, pull-ups on port 2
  assign data_i = data_oe ? data_o : hd;
  assign p2_i = {grant_n, 7'h7f} & (~p2_oe | p2_o);
  slave_host_buffer_port slave_host_buffer_port_i (.sys_clk_i(clk), .rstn_i(rstn),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .cs_n_i(cs_n),
    .cmd_data_select_i(cds), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(data_i), .data_o(data_o),
    .data_oe_o(data_oe), .p2_i(p2_i), .p2_o(p2_o), .p2_oe_o(p2_oe), .irq_o(irq));
  host_master_model host_master_model_i (.sys_clk_i(clk), .data_o(data_o), .cs_n_o(cs_n),
    .cmd_data_select_o(cds), .rd_n_o(rd_n), .wr_n_o(wr_n), .hd_o(hd), .grant_n_o(grant_n));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  // apb transfer, sampled at rising edges, ends half a cycle after an idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20)
    begin
      n_fail++;
      $display("[FAIL] %0t apb timeout", $time);
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rd_chk
  // main sequence
  initial
  begin
    {psel, pen, pwr, paddr, pwdata, rstn, n_fail, n_compared} = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 9; i++)
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(r, rows[i].e);
      chk(32'(e), 32'(rows[i].er));
    end
    $display("register rows done");
    apb(1'b1, CTRL_OFS, 32'h1);
    chk(32'(p2_oe[7:4]), 32'h3);
    chk(32'(p2_o[5:4]), 32'h0);
    rd_chk(STATUS_OFS, 32'h50);
    host_master_model_i.xfer(1'b1, 1'b1, 1'b0, 8'h3c, d);
    rd_chk(STATUS_OFS, 32'h5a);
    apb(1'b1, OUTBUF_OFS, 32'hc3);
    chk(32'(p2_o[5:4]), 32'h3);
    rd_chk(INBUF_OFS, 32'h3c);
    host_master_model_i.xfer(1'b0, 1'b0, 1'b0, 8'h00, d);
    chk(32'(d), 32'hc3);
    rd_chk(STATUS_OFS, 32'h58);
    host_master_model_i.xfer(1'b1, 1'b0, 1'b0, 8'h11, d);
    rd_chk(STATUS_OFS, 32'h52);
    rd_chk(INBUF_OFS, 32'h11);
    $display("flag test done");
    rd_chk(IRQ_STAT_OFS, 32'h3);
    chk(32'(irq), 32'h0);
    apb(1'b1, IRQ_MASK_OFS, 32'h2);
    chk(32'(irq), 32'h1);
    apb(1'b1, IRQ_STAT_OFS, 32'h2);
    chk(32'(irq), 32'h0);
    rd_chk(IRQ_STAT_OFS, 32'h1);
    apb(1'b1, IRQ_STAT_OFS, 32'h1);
    apb(1'b1, IRQ_MASK_OFS, 32'h4);
    $display("irq test done");
    apb(1'b1, CTRL_OFS, 32'h3);
    apb(1'b1, CTRL_OFS, 32'h7);
    chk(32'(p2_oe[7:6]), 32'h1);
    chk(32'(p2_o[6]), 32'h1);
    apb(1'b1, OUTBUF_OFS, 32'h96);
    host_master_model_i.xfer(1'b0, 1'b0, 1'b1, 8'h00, d);
    chk(32'(d), 32'h96);
    chk(32'(p2_o[6]), 32'h0);
    chk(32'(irq), 32'h1);
    apb(1'b1, CTRL_OFS, 32'h7);
    host_master_model_i.xfer(1'b1, 1'b0, 1'b1, 8'h69, d);
    rd_chk(STATUS_OFS, 32'h52);
    rd_chk(INBUF_OFS, 32'h69);
    $display("dma test done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(negedge clk);
    chk(32'(p2_oe), 32'h0);
    rd_chk(CTRL_OFS, 32'h0);
    $display("reset test done");
    conclude();
  end
endmodule : slave_host_buffer_port_tb_top
bind slave_host_buffer_port slave_host_buffer_port_asserts slave_host_buffer_port_asserts_i (
  .sys_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o, .cs_n_i,
  .cmd_data_select_i, .rd_n_i, .wr_n_i, .data_oe_o, .p2_i, .p2_o, .p2_oe_o);
`default_nettype wire
